// ### hdl/rer_pkg.sv
// Purpose: Constants for the regulator enable request register block.
// Assumes: 8-bit register addresses and 16-bit register data.
// Notes: Field positions follow the register layout; status offset is local.
//
// Functional notes
// [RQ1] Register 0Dh: bit 9 linreg b, bit 8 linreg a, bits 5..0 converters.
// [RQ2] State machine reset returns every request bit to its default, beating writes.
// [RQ3] Defaults come from a fixed mask option; all printed defaults are zero. rst_n_in reset loads REQ_DEFAULT, not MASK_DEFAULT.
// [RQ4] A request of 1 may still be held off by internal protection.
// [RQ5] True regulator on/off state is readable in a separate status register.
// [RQ6] Reading the enable register returns requests, not actual regulator state.
package rer_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] REQ_OFFSET = 8'h0D;
  localparam logic [7:0] STATUS_OFFSET = 8'h40;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_REG = 8;

  // ---------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------
  localparam int LINREG_B_POS = 9;
  localparam int LINREG_A_POS = 8;
  localparam int BUCK_MSB = 5;
  localparam int BUCK_LSB = 0;
  localparam logic [15:0] REQ_FIELD_MASK = 16'h033F;

  // Mask option default for all request bits.
  localparam logic [15:0] REQ_DEFAULT = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

endpackage

// ### hdl/rer_sync.sv
// Purpose: Two-stage synchroniser, one instance per bit through a generate loop.
// Assumes: Inputs are asynchronous to the clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module rer_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          stage1[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          stage1[gi] <= async_in[gi];
          sync_out[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### hdl/rer_top.sv
// Purpose: Regulator enable request register with actual-state status readback.
// Assumes: Register port and state machine reset are on ref_clk_in.
// Notes: Protection hold inputs arrive from analogue logic and are synchronised.
`timescale 1ns/1ps
`default_nettype none
module rer_top #(
  parameter logic [15:0] MASK_DEFAULT = rer_pkg::REQ_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psm_reset_in,
  input wire logic [rer_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [rer_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [rer_pkg::NUM_REG-1:0] protect_hold_in,
  output logic [rer_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [rer_pkg::NUM_REG-1:0] reg_on_req_out,
  output logic [rer_pkg::NUM_REG-1:0] reg_on_out
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [15:0] req;
  logic [15:0] next_req;
  logic [7:0] hold_sync;
  logic [7:0] next_on_req;
  logic [7:0] next_on;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic [15:0] status_word;

  logic linreg_b_on_req;
  logic linreg_a_on_req;
  logic buckboost_f_on_req;
  logic buckboost_e_on_req;
  logic buckboost_d_on_req;
  logic buckboost_c_on_req;
  logic buckboost_b_on_req;
  logic buckboost_a_on_req;

  rer_sync #(
    .WIDTH(rer_pkg::NUM_REG)
  ) u_hold_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(protect_hold_in),
    .sync_out(hold_sync)
  );

  assign linreg_b_on_req = req[rer_pkg::LINREG_B_POS];
  assign linreg_a_on_req = req[rer_pkg::LINREG_A_POS];
  assign buckboost_f_on_req = req[rer_pkg::BUCK_LSB + 5];
  assign buckboost_e_on_req = req[rer_pkg::BUCK_LSB + 4];
  assign buckboost_d_on_req = req[rer_pkg::BUCK_LSB + 3];
  assign buckboost_c_on_req = req[rer_pkg::BUCK_LSB + 2];
  assign buckboost_b_on_req = req[rer_pkg::BUCK_LSB + 1];
  assign buckboost_a_on_req = req[rer_pkg::BUCK_LSB];

  // -----------------------------------------------------------------------
  // Request register
  // -----------------------------------------------------------------------
  always_comb begin
    next_req = req;
    if (psm_reset_in) begin
      // The state machine reset beats a write in the same cycle.
      next_req = MASK_DEFAULT & rer_pkg::REQ_FIELD_MASK; // [RQ2] [RQ3]
    end else if (reg_wr_in && reg_addr_in == rer_pkg::REQ_OFFSET) begin
      next_req = reg_wdata_in & rer_pkg::REQ_FIELD_MASK; // [RQ1]
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req <= rer_pkg::REQ_DEFAULT; // [RQ3]
    end else begin
      req <= next_req;
    end
  end

  // -----------------------------------------------------------------------
  // Regulator drive and status
  // -----------------------------------------------------------------------
  always_comb begin
    next_on_req = {linreg_b_on_req, linreg_a_on_req, buckboost_f_on_req,
                   buckboost_e_on_req, buckboost_d_on_req, buckboost_c_on_req,
                   buckboost_b_on_req, buckboost_a_on_req};
    // Protection overrides a request; software sees the refusal in status.
    next_on = next_on_req & ~hold_sync; // [RQ4]
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_on_req_out <= 8'h00;
      reg_on_out <= 8'h00;
    end else begin
      reg_on_req_out <= next_on_req;
      reg_on_out <= next_on;
    end
  end

  // Status uses the same bit positions as the request register.
  assign status_word = {6'h00, reg_on_out[7], reg_on_out[6], 2'h0,
                        reg_on_out[rer_pkg::BUCK_MSB:rer_pkg::BUCK_LSB]}; // [RQ5]

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  always_comb begin
    next_rdata = rer_pkg::ZERO_WORD;
    next_rvalid = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        rer_pkg::REQ_OFFSET: next_rdata = req; // [RQ6]
        rer_pkg::STATUS_OFFSET: next_rdata = status_word; // [RQ5]
        default: next_rdata = rer_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= rer_pkg::ZERO_WORD;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Read data is zero outside an answer cycle, so several banks can share an OR-ed read bus.
  assign reg_rdata_out = rdata;
  assign reg_rvalid_out = rvalid;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_write_stores_req: assert property ( // [RQ1]
    (reg_wr_in && !psm_reset_in && reg_addr_in == rer_pkg::REQ_OFFSET) |=>
      (req == ($past(reg_wdata_in) & rer_pkg::REQ_FIELD_MASK)))
    else $error("request write not stored");

  a_linreg_b_pos: assert property ( // [RQ1]
    (reg_wr_in && !psm_reset_in && reg_addr_in == rer_pkg::REQ_OFFSET) ##2
      1'b1 |-> reg_on_req_out[7] == $past(reg_wdata_in[9], 2))
    else $error("linreg b request not at bit 9");

  a_psm_reset_wins: assert property ( // [RQ2]
    psm_reset_in |=> req == (MASK_DEFAULT & rer_pkg::REQ_FIELD_MASK))
    else $error("state machine reset did not restore defaults");

  a_other_addr_keep: assert property ( // [RQ1]
    (!psm_reset_in && !(reg_wr_in && reg_addr_in == rer_pkg::REQ_OFFSET)) |=>
      $stable(req))
    else $error("request changed without cause");

  a_reserved_zero: assert property ( // [RQ1]
    (req & ~rer_pkg::REQ_FIELD_MASK) == rer_pkg::ZERO_WORD)
    else $error("reserved request bit set");

  a_hold_blocks_on: assert property ( // [RQ4]
    hold_sync[0] |=> !reg_on_out[0])
    else $error("held regulator turned on");

  a_on_follows_req: assert property ( // [RQ4]
    (req[rer_pkg::BUCK_LSB + 1] && !hold_sync[1]) |=> reg_on_out[1])
    else $error("unheld request did not turn regulator on");

  a_read_req: assert property ( // [RQ6]
    (reg_rd_in && reg_addr_in == rer_pkg::REQ_OFFSET) |=>
      (reg_rvalid_out && reg_rdata_out == $past(req)))
    else $error("request read returned wrong value");

  a_read_status: assert property ( // [RQ5]
    (reg_rd_in && reg_addr_in == rer_pkg::STATUS_OFFSET) |=>
      (reg_rdata_out[rer_pkg::BUCK_MSB:rer_pkg::BUCK_LSB] ==
       $past(reg_on_out[5:0])))
    else $error("status read does not show actual state");

  a_read_answer: assert property ( // [RQ6]
    reg_rd_in |=> reg_rvalid_out)
    else $error("read strobe got no answer");

  a_idle_read_zero: assert property ( // [RQ6]
    !reg_rd_in |=> (!reg_rvalid_out && reg_rdata_out == rer_pkg::ZERO_WORD))
    else $error("read port not idle without a read");

  a_unmapped_zero: assert property ( // [RQ1]
    (reg_rd_in && reg_addr_in != rer_pkg::REQ_OFFSET &&
     reg_addr_in != rer_pkg::STATUS_OFFSET) |=>
      (reg_rvalid_out && reg_rdata_out == rer_pkg::ZERO_WORD))
    else $error("unmapped read returned data");

  a_on_req_mirror: assert property ( // [RQ1]
    1'b1 |=> reg_on_req_out == {$past(req[rer_pkg::LINREG_B_POS]),
      $past(req[rer_pkg::LINREG_A_POS]), $past(req[rer_pkg::BUCK_MSB:rer_pkg::BUCK_LSB])})
    else $error("request outputs do not mirror the register");

  a_status_linreg: assert property ( // [RQ5]
    (reg_rd_in && reg_addr_in == rer_pkg::STATUS_OFFSET) |=>
      (reg_rdata_out[rer_pkg::LINREG_B_POS] == $past(reg_on_out[7]) &&
       reg_rdata_out[rer_pkg::LINREG_A_POS] == $past(reg_on_out[6])))
    else $error("status read does not show linear regulator state");

  a_status_reserved: assert property ( // [RQ5]
    (reg_rd_in && reg_addr_in == rer_pkg::STATUS_OFFSET) |=>
      ((reg_rdata_out & ~rer_pkg::REQ_FIELD_MASK) == rer_pkg::ZERO_WORD))
    else $error("status read shows a reserved bit");

  a_hold_linreg_b: assert property ( // [RQ4]
    hold_sync[7] |=> !reg_on_out[7])
    else $error("held linear regulator turned on");

  c_refused_request: cover property (req[0] && hold_sync[0] ##1 !reg_on_out[0]);
  c_reset_over_write: cover property (psm_reset_in && reg_wr_in &&
    reg_addr_in == rer_pkg::REQ_OFFSET);
  c_status_read: cover property (reg_rd_in && reg_addr_in == rer_pkg::STATUS_OFFSET);
  c_all_on: cover property (reg_on_out == 8'hFF);

endmodule
`default_nettype wire

// ### verif/rer_top_test.sv
// Purpose: Self-checking bench for the regulator enable request register.
// Assumes: Mask option left at its all-zero default; inputs change on falling edges.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
`default_nettype none
module rer_top_test;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psm_reset_in = 1'b0;
  logic [rer_pkg::ADDR_W-1:0] reg_addr_in = 8'h00;
  logic [rer_pkg::DATA_W-1:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [rer_pkg::NUM_REG-1:0] protect_hold_in = 8'h00;
  logic [rer_pkg::DATA_W-1:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic [rer_pkg::NUM_REG-1:0] reg_on_req_out;
  logic [rer_pkg::NUM_REG-1:0] reg_on_out;
  int fail_count = 0;
  int checks_done = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  rer_top i_dut (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .psm_reset_in(psm_reset_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .protect_hold_in(protect_hold_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .reg_on_req_out(reg_on_req_out),
    .reg_on_out(reg_on_out)
  );

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(negedge ref_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = addr;
    reg_wdata_in = data;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask

  // The answer stands for the one cycle after the taking edge; look at it mid-cycle.
  task automatic rd_check(input string name, input logic [7:0] addr, input logic [15:0] exp);
    @(negedge ref_clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = addr;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    cmp("rvalid", 16'h0001, {15'h0000, reg_rvalid_out});
    cmp(name, exp, reg_rdata_out);
    @(negedge ref_clk_in);
    cmp("rvalid_end", 16'h0000, {15'h0000, reg_rvalid_out});
    cmp("rdata_end", 16'h0000, reg_rdata_out);
  endtask

  // Long enough for the register, output stage and the hold synchroniser.
  task automatic settle();
    repeat (5) @(negedge ref_clk_in);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic test_reset();
    cmp("on_req", 16'h0000, {8'h00, reg_on_req_out});
    rd_check("req", 8'h0D, 16'h0000);
    rd_check("status", 8'h40, 16'h0000);
  endtask

  task automatic test_bit_map();
    logic [15:0] data;
    for (int i = 0; i < 8; i++) begin
      data = (i < 6) ? (16'h0001 << i) : (16'h0100 << (i - 6));
      wr(8'h0D, data);
      settle();
      cmp("on_req", {8'h00, 8'h01 << i}, {8'h00, reg_on_req_out});
      rd_check("req", 8'h0D, data);
    end
    wr(8'h0D, 16'hFFFF);
    rd_check("req", 8'h0D, 16'h033F);
  endtask

  // Linreg b and converter a are held off while both still request on.
  task automatic test_hold();
    protect_hold_in = 8'h81;
    settle();
    cmp("on_req", 16'h00FF, {8'h00, reg_on_req_out});
    cmp("on", 16'h007E, {8'h00, reg_on_out});
    rd_check("req", 8'h0D, 16'h033F);
    rd_check("status", 8'h40, 16'h013E);
    protect_hold_in = 8'h00;
    settle();
    cmp("on", 16'h00FF, {8'h00, reg_on_out});
  endtask

  // State machine reset beats a write in the same cycle.
  task automatic test_psm();
    psm_reset_in = 1'b1;
    wr(8'h0D, 16'h033F);
    psm_reset_in = 1'b0;
    settle();
    cmp("on_req", 16'h0000, {8'h00, reg_on_req_out});
    rd_check("req", 8'h0D, 16'h0000);
    wr(8'h0E, 16'hFFFF);
    rd_check("unmapped", 8'h0E, 16'h0000);
    rd_check("req", 8'h0D, 16'h0000);
  endtask

  // ---------------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    test_reset();
    test_bit_map();
    test_hold();
    test_psm();
    test_done();
  end

  // The sequence needs well under a thousand cycles.
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
